// >>> core/psa_pkg.sv
// package: register map, field layout, reset values, codes and timing for the status and alarm block
package psa_pkg;
   // clock and command processing time
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned CMD_PROC_NS = 500;
   localparam int unsigned CMD_PROC_CYC = (CMD_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CMD_PROC_LOAD = 4'(CMD_PROC_CYC);
   // register byte offsets
   localparam logic [4:0] OFF_STATUS = 5'h00;
   localparam logic [4:0] OFF_ALARM = 5'h04;
   localparam logic [4:0] OFF_ALARM_EN = 5'h08;
   localparam logic [4:0] OFF_ALARM_RAW = 5'h0C;
   localparam logic [4:0] OFF_CMD = 5'h10;
   localparam logic [4:0] OFF_CMD_STAT = 5'h14;
   // status word field positions
   localparam int BIT_SEC_LO = 8;
   localparam int BIT_OTP_BLOCKED = 7;
   localparam int BIT_OTP_PENDING = 6;
   localparam int BIT_OPEN_WIRE = 5;
   localparam int BIT_WATCHDOG = 4;
   localparam int BIT_FULL_RESET = 3;
   localparam int BIT_LP_PERMIT = 2;
   localparam int BIT_SOFT_CHARGE = 1;
   localparam int BIT_EDIT = 0;
   // alarm word: bit 8 reserved, bit 1 single scan done
   localparam int BIT_SCAN_DONE = 1;
   localparam logic [15:0] ALARM_VALID_MASK = 16'hFEFF;
   // command status bits
   localparam int BIT_CMD_BUSY = 0;
   localparam int BIT_CMD_REJECTED = 1;
   // reset values
   localparam logic [15:0] ALARM_EN_RST = 16'h0000;
   localparam logic FULL_RESET_RST = 1'b1;
   localparam logic OTP_BLOCKED_RST = 1'b1;
   // security states
   typedef enum logic [1:0] {
      PSA_SEC_INIT = 2'b00,
      PSA_SEC_OPEN = 2'b01,
      PSA_SEC_PARTLY = 2'b10,
      PSA_SEC_LOCKED = 2'b11
   } psa_sec_t;
   // host command codes
   typedef enum logic [7:0] {
      PSA_CMD_NONE = 8'h00,
      PSA_CMD_EDIT_ENTER = 8'h01,
      PSA_CMD_EDIT_EXIT = 8'h02,
      PSA_CMD_SLEEP_EN = 8'h03,
      PSA_CMD_SLEEP_DIS = 8'h04
   } psa_cmd_t;
   // command engine states
   typedef enum logic [1:0] {
      PSA_CS_IDLE = 2'b00,
      PSA_CS_EXEC = 2'b01,
      PSA_CS_DONE = 2'b10
   } psa_cstate_t;
endpackage

// >>> core/psa_alarm_latch.sv
// latched alarm word with enable gating, write-one-to-clear and alert output
`timescale 1ns/1ns
module psa_alarm_latch (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // event side
   input wire logic [15:0] raw,
   input wire logic [15:0] enable,
   input wire logic [15:0] clr,
   // results
   output logic [15:0] latched,
   output logic alert
);
   import psa_pkg::*;

   // one latch per bit; a set in the clearing cycle wins
   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_bit
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               latched[i] <= 1'b0;
            end else if (ALARM_VALID_MASK[i] && raw[i] && enable[i]) begin
               latched[i] <= 1'b1; // R20 R22
            end else if (clr[i]) begin
               latched[i] <= 1'b0; // R19
            end
         end
      end
   endgenerate

   // any latched flag drives the alert pin
   assign alert = |latched; // R18

   a_set_wins: assert property (@(posedge mclk) disable iff (!rst_n) // R22
      (raw[0] && enable[0] && clr[0]) |=> latched[0])
      else $error("alarm set lost against clear");
   a_clear_one: assert property (@(posedge mclk) disable iff (!rst_n) // R19
      (clr[5] && !(raw[5] && enable[5])) |=> !latched[5])
      else $error("alarm clear ignored");
   a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R18
      !latched[8] && (alert == (latched != 16'h0000)))
      else $error("reserved alarm bit or alert wrong");
endmodule

// >>> core/psa_cmd_fsm.sv
// host command engine: takes a command, checks access, processes it, then pulses its effect
`timescale 1ns/1ns
module psa_cmd_fsm (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // command in
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire psa_pkg::psa_sec_t sec,
   // state out
   output logic busy,
   output logic rejected,
   // completion pulses
   output logic edit_enter_p,
   output logic edit_exit_p,
   output logic sleep_en_p,
   output logic sleep_dis_p
);
   import psa_pkg::*;

   psa_cstate_t state;
   logic [7:0] code;
   logic [3:0] cnt;
   logic refuse;

   // locked state and pre-init refuse the restricted commands; unknown codes refused always
   always_comb begin
      case (cmd_code)
         PSA_CMD_EDIT_ENTER,
         PSA_CMD_SLEEP_EN,
         PSA_CMD_SLEEP_DIS: refuse = (sec == PSA_SEC_LOCKED) || (sec == PSA_SEC_INIT); // R2 R4
         PSA_CMD_EDIT_EXIT: refuse = 1'b0;
         default: refuse = 1'b1;
      endcase
   end

   // sequencer; commands arriving while busy are dropped
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PSA_CS_IDLE;
         code <= 8'h00;
         cnt <= 4'h0;
         rejected <= 1'b0;
      end else begin
         case (state)
            PSA_CS_IDLE: begin
               if (cmd_valid) begin
                  rejected <= refuse;
                  if (!refuse) begin
                     code <= cmd_code;
                     cnt <= CMD_PROC_LOAD;
                     state <= PSA_CS_EXEC;
                  end
               end
            end
            PSA_CS_EXEC: begin
               cnt <= cnt - 4'h1;
               if (cnt == 4'h1) begin
                  state <= PSA_CS_DONE;
               end
            end
            PSA_CS_DONE: state <= PSA_CS_IDLE;
            default: state <= PSA_CS_IDLE;
         endcase
      end
   end

   // effects only once processing is complete
   assign busy = (state != PSA_CS_IDLE);
   assign edit_enter_p = (state == PSA_CS_DONE) && (code == PSA_CMD_EDIT_ENTER); // R16
   assign edit_exit_p = (state == PSA_CS_DONE) && (code == PSA_CMD_EDIT_EXIT);
   assign sleep_en_p = (state == PSA_CS_DONE) && (code == PSA_CMD_SLEEP_EN); // R13
   assign sleep_dis_p = (state == PSA_CS_DONE) && (code == PSA_CMD_SLEEP_DIS);

   a_locked_refuse: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      (!busy && cmd_valid && cmd_code == PSA_CMD_EDIT_ENTER && sec == PSA_SEC_LOCKED) |=> (!busy && rejected))
      else $error("restricted command taken while locked");
endmodule

// >>> core/psa_status_top.sv
// status word, security access gating and alarm word behind an Avalon-MM slave
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
// Functional notes
// R1 - status bits 9:8 give security state, zero until initialization completes
// R2 - locked state: no configuration reads or writes, restricted commands refused
// R3 - partly-open state: configuration readable, writable only in settings-edit mode
// R4 - open state: unrestricted access, every command accepted; code gates writes on settings-edit flag, refuses unknown codes
// R5 - host should change configuration only in settings-edit mode
// R6 - otp write-blocked at bit 7; set whenever write-pending is clear normally
// R7 - entering edit mode evaluates otp conditions once; flag then frozen during edit
// R8 - write-pending at bit 6 set while otp data waits, until all written
// R9 - write-pending never set while in settings-edit mode
// R10 - open-wire flag at bit 5 only during checks, never when disabled
// R11 - bit 4 shows whether last reset came from internal watchdog
// R12 - full-reset flag at bit 3 set by reset, cleared on edit exit
// R13 - low-power permit at bit 2 from config default, then host commands
// R14 - low-power entry only with permit set and other criteria met
// R15 - bit 1 soft-charge mode; soft-charge switch replaces main charge switch
// R16 - bit 0 settings-edit set only after enter command fully processed
// R17 - configuration changes accepted only while settings-edit flag set
// R18 - alarm word bits 15:9 and 7:0 latched, bit 8 reserved, any drives alert
// R19 - writing one clears an alarm bit, zero leaves it
// R20 - latched alarm captured from raw flag only when enabled
// R21 - single-scan raw flag set on each completed scan when enabled
// R22 - simultaneous event and clear on an alarm bit keeps it set
// R23 - host writes to the status word are ignored
module psa_status_top (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // security and initialization
   input wire psa_pkg::psa_sec_t sec_state,
   input wire logic init_done,
   // otp programming
   input wire logic otp_cond_ok,
   input wire logic otp_data_waiting,
   input wire logic otp_all_written,
   // open-wire check, reset cause, low power
   input wire logic ow_enable,
   input wire logic ow_check_running,
   input wire logic wd_reset_cause,
   input wire logic cfg_sleep_default,
   input wire logic sleep_criteria_ok,
   // charging
   input wire logic soft_charge_mode,
   input wire logic charge_request,
   // alarm sources
   input wire logic scan_done,
   input wire logic [15:0] alarm_raw_in,
   // outputs to device logic
   output logic cfg_rd_allow,
   output logic cfg_wr_allow,
   output logic settings_edit_flag,
   output logic enter_low_power,
   output logic soft_charge_switch,
   output logic main_charge_switch,
   output logic alert_out
);
   import psa_pkg::*;

   logic ack;
   logic req;
   logic acc_wr;
   logic [31:0] next_rdata;
   logic otp_blocked;
   logic otp_pending;
   logic wd_flag;
   logic full_reset;
   logic lp_permit;
   logic started;
   logic [15:0] alarm_en;
   logic [15:0] alarm_raw;
   logic [15:0] alarm_latched;
   logic [15:0] alarm_clr;
   logic [15:0] status_word;
   psa_sec_t sec_field;
   logic cmd_busy;
   logic cmd_rejected;
   logic edit_enter_p;
   logic edit_exit_p;
   logic sleep_en_p;
   logic sleep_dis_p;

   // address match, used by read mux and write decode
   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction

   // one wait state: read data captured on first edge, writes land on second
   assign req = avs_read || avs_write;
   assign avs_waitrequest = req && !ack;
   assign acc_wr = avs_write && ack;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req && !ack;
      end
   end

   // security field reads zero until initialization is done
   assign sec_field = init_done ? sec_state : PSA_SEC_INIT; // R1

   // configuration access gating
   always_comb begin
      case (sec_field)
         PSA_SEC_OPEN: begin
            cfg_rd_allow = 1'b1; // R4
            cfg_wr_allow = settings_edit_flag; // R4 R17
         end
         PSA_SEC_PARTLY: begin
            cfg_rd_allow = 1'b1;
            cfg_wr_allow = settings_edit_flag; // R3
         end
         default: begin
            cfg_rd_allow = 1'b0; // R2
            cfg_wr_allow = 1'b0;
         end
      endcase
   end

   // settings-edit flag follows completed enter and exit commands
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         settings_edit_flag <= 1'b0;
      end else if (edit_enter_p) begin
         settings_edit_flag <= 1'b1; // R16
      end else if (edit_exit_p) begin
         settings_edit_flag <= 1'b0;
      end
   end

   // otp pending: set outside edit mode only, new data wins over completion
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         otp_pending <= 1'b0;
      end else if (otp_data_waiting && !settings_edit_flag) begin
         otp_pending <= 1'b1; // R8 R9
      end else if (otp_all_written) begin
         otp_pending <= 1'b0; // R8
      end
   end

   // otp blocked: sampled on edit entry and frozen, else tracks conditions
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         otp_blocked <= OTP_BLOCKED_RST;
      end else if (edit_enter_p) begin
         otp_blocked <= !otp_cond_ok; // R7
      end else if (!settings_edit_flag) begin
         otp_blocked <= otp_pending ? !otp_cond_ok : 1'b1; // R6
      end
   end

   // first cycle after reset release captures reset cause and sleep default
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         started <= 1'b0;
         wd_flag <= 1'b0;
      end else if (!started) begin
         started <= 1'b1;
         wd_flag <= wd_reset_cause; // R11
      end
   end

   // low-power permit: default from configuration, then host commands
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lp_permit <= 1'b0;
      end else if (!started) begin
         lp_permit <= cfg_sleep_default; // R13
      end else if (sleep_en_p) begin
         lp_permit <= 1'b1; // R13
      end else if (sleep_dis_p) begin
         lp_permit <= 1'b0;
      end
   end

   // full-reset flag stays until edit mode is left
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         full_reset <= FULL_RESET_RST; // R12
      end else if (edit_exit_p) begin
         full_reset <= 1'b0; // R12
      end
   end

   // low power and charge switch steering
   assign enter_low_power = lp_permit && sleep_criteria_ok; // R14
   assign soft_charge_switch = charge_request && soft_charge_mode; // R15
   assign main_charge_switch = charge_request && !soft_charge_mode; // R15

   // status word, read-only: no write path reaches it
   always_comb begin
      status_word = 16'h0000; // R23
      status_word[BIT_SEC_LO +: 2] = sec_field; // R1
      status_word[BIT_OTP_BLOCKED] = otp_blocked;
      status_word[BIT_OTP_PENDING] = otp_pending;
      status_word[BIT_OPEN_WIRE] = ow_enable && ow_check_running; // R10
      status_word[BIT_WATCHDOG] = wd_flag;
      status_word[BIT_FULL_RESET] = full_reset;
      status_word[BIT_LP_PERMIT] = lp_permit;
      status_word[BIT_SOFT_CHARGE] = soft_charge_mode; // R15
      status_word[BIT_EDIT] = settings_edit_flag;
   end

   // alarm enable register, byte lanes honoured
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_en <= ALARM_EN_RST;
      end else if (acc_wr && hit(avs_address, OFF_ALARM_EN)) begin
         if (avs_byteenable[0]) begin
            alarm_en[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            alarm_en[15:8] <= avs_writedata[15:8];
         end
      end
   end

   // raw alarm flags; scan completion feeds its bit when enabled
   always_comb begin
      alarm_raw = alarm_raw_in & ALARM_VALID_MASK;
      alarm_raw[BIT_SCAN_DONE] = scan_done && alarm_en[BIT_SCAN_DONE]; // R21
   end

   // write-one-to-clear strobes for the latched word
   always_comb begin
      alarm_clr = 16'h0000;
      if (acc_wr && hit(avs_address, OFF_ALARM)) begin
         alarm_clr = avs_writedata[15:0] & {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}}; // R19
      end
   end

   psa_alarm_latch u_alarm (
      .mclk(mclk),
      .rst_n(rst_n),
      .raw(alarm_raw),
      .enable(alarm_en),
      .clr(alarm_clr),
      .latched(alarm_latched),
      .alert(alert_out)
   );

   psa_cmd_fsm u_cmd (
      .mclk(mclk),
      .rst_n(rst_n),
      .cmd_valid(acc_wr && hit(avs_address, OFF_CMD) && avs_byteenable[0]),
      .cmd_code(avs_writedata[7:0]),
      .sec(sec_field),
      .busy(cmd_busy),
      .rejected(cmd_rejected),
      .edit_enter_p(edit_enter_p),
      .edit_exit_p(edit_exit_p),
      .sleep_en_p(sleep_en_p),
      .sleep_dis_p(sleep_dis_p)
   );

   // read mux; unmapped addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit(avs_address, OFF_STATUS)) begin
         next_rdata[15:0] = status_word;
      end else if (hit(avs_address, OFF_ALARM)) begin
         next_rdata[15:0] = alarm_latched;
      end else if (hit(avs_address, OFF_ALARM_EN)) begin
         next_rdata[15:0] = alarm_en;
      end else if (hit(avs_address, OFF_ALARM_RAW)) begin
         next_rdata[15:0] = alarm_raw;
      end else if (hit(avs_address, OFF_CMD_STAT)) begin
         next_rdata[BIT_CMD_BUSY] = cmd_busy;
         next_rdata[BIT_CMD_REJECTED] = cmd_rejected;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack) begin
         avs_readdata <= next_rdata;
      end
   end

   // checks
   sequence s_req_first;
      req && avs_waitrequest;
   endsequence
   sequence s_edit_done;
      edit_enter_p ##1 settings_edit_flag;
   endsequence

   a_bus_one_wait: assert property (@(posedge mclk) disable iff (!rst_n)
      s_req_first |=> !avs_waitrequest)
      else $error("waitrequest held too long");
   a_sec_init_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R1
      !init_done |-> (status_word[9:8] == 2'b00))
      else $error("security field set before init");
   a_locked_no_cfg: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      (init_done && sec_state == PSA_SEC_LOCKED) |-> (!cfg_rd_allow && !cfg_wr_allow))
      else $error("configuration reachable while locked");
   a_partly_wr_edit: assert property (@(posedge mclk) disable iff (!rst_n) // R3
      (init_done && sec_state == PSA_SEC_PARTLY) |-> (cfg_rd_allow && cfg_wr_allow == settings_edit_flag))
      else $error("partly-open access wrong");
   a_cfg_wr_edit: assert property (@(posedge mclk) disable iff (!rst_n) // R17
      cfg_wr_allow |-> settings_edit_flag)
      else $error("configuration write outside edit");
   a_otp_write_blocked_idle_set: assert property (@(posedge mclk) disable iff (!rst_n) // R6
      (!settings_edit_flag && !otp_pending && !edit_enter_p) |=> (otp_blocked || settings_edit_flag))
      else $error("otp blocked clear without pending");
   a_otp_write_blocked_frozen: assert property (@(posedge mclk) disable iff (!rst_n) // R7
      (settings_edit_flag && $past(settings_edit_flag)) |-> $stable(otp_blocked))
      else $error("otp blocked changed during edit");
   a_pend_not_edit: assert property (@(posedge mclk) disable iff (!rst_n) // R9
      $rose(otp_pending) |-> !$past(settings_edit_flag))
      else $error("otp pending set in edit mode");
   a_ow_disabled: assert property (@(posedge mclk) disable iff (!rst_n) // R10
      !ow_enable |-> !status_word[BIT_OPEN_WIRE])
      else $error("open-wire flag while disabled");
   a_por_exit: assert property (@(posedge mclk) disable iff (!rst_n) // R12
      $fell(settings_edit_flag) |-> !full_reset)
      else $error("full-reset flag kept after edit exit");
   a_lp_gate: assert property (@(posedge mclk) disable iff (!rst_n) // R14
      enter_low_power |-> (status_word[BIT_LP_PERMIT] && sleep_criteria_ok))
      else $error("low power without permit");
   a_soft_excl: assert property (@(posedge mclk) disable iff (!rst_n) // R15
      !(soft_charge_switch && main_charge_switch))
      else $error("both charge switches on");
   a_edit_cmd: assert property (@(posedge mclk) disable iff (!rst_n) // R16
      $rose(settings_edit_flag) |-> $past(edit_enter_p))
      else $error("edit flag set without completed command");
   a_edit_seq: assert property (@(posedge mclk) disable iff (!rst_n) // R16
      edit_enter_p |-> s_edit_done)
      else $error("edit flag not set after command");
   a_status_ro: assert property (@(posedge mclk) disable iff (!rst_n) // R23
      (acc_wr && hit(avs_address, OFF_STATUS)) |=> $stable(full_reset) || $past(edit_exit_p))
      else $error("status changed by host write");
endmodule

// >>> verif/psa_host_model.sv
// host controller model: avalon-mm master that carries out single reads and writes
`timescale 1ns/1ns
module psa_host_model (
   // clock
   input wire logic mclk,
   // avalon-mm master side
   output logic [4:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   // idle bus at time zero
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
   end
   // one transfer; request held until waitrequest is seen low at a rising edge
   // the bench issues its alarm-enable and status writes outside edit windows
   task automatic xfer(input bit w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q, output bit ok);
      bit lo;
      int n;
      lo = 0;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      // waitrequest and read data are taken at the rising edge itself, before that edge's updates land
      while (!lo && n < 30) begin
         @(posedge mclk);
         n++;
         lo = (avs_waitrequest === 1'b0);
      end
      q = avs_readdata;
      ok = lo;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~d; // released data does not keep its last value
   endtask
endmodule

// >>> verif/pack_status_and_alarm_latch_test.sv
// testbench for the status word and latched alarm block
`timescale 1ns/1ns
module pack_status_and_alarm_latch_test;
   import psa_pkg::*;
   logic mclk, rst_n, init_done, otp_cond_ok, otp_data_waiting, otp_all_written, ow_enable;
   logic ow_check_running, wd_reset_cause, cfg_sleep_default, sleep_criteria_ok;
   logic soft_charge_mode, charge_request, scan_done;
   logic [15:0] alarm_raw_in;
   psa_sec_t sec_state;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic avs_read, avs_write, avs_waitrequest, cfg_rd_allow, cfg_wr_allow, settings_edit_flag;
   logic enter_low_power, soft_charge_switch, main_charge_switch, alert_out;
   int fail_count = 0;
   int comparisons = 0;
   // design and host model
   psa_status_top u_psa_status_top (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sec_state, .init_done,
      .otp_cond_ok, .otp_data_waiting, .otp_all_written, .ow_enable, .ow_check_running,
      .wd_reset_cause, .cfg_sleep_default, .sleep_criteria_ok, .soft_charge_mode, .charge_request,
      .scan_done, .alarm_raw_in, .cfg_rd_allow, .cfg_wr_allow, .settings_edit_flag,
      .enter_low_power, .soft_charge_switch, .main_charge_switch, .alert_out);
   psa_host_model u_psa_host_model (.mclk, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest);
   // clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic print_verdict;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic bus(input bit w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      bit ok;
      u_psa_host_model.xfer(w, a, d, q, ok);
      if (!ok) begin
         fail_count++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(nm, e, q);
   endtask
   // masked status word compare
   task automatic st(input string nm, input logic [15:0] m, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, OFF_STATUS, 32'h00000000, q);
      chk(nm, {16'h0000, e & m}, {16'h0000, q[15:0] & m});
   endtask
   // command write, then wait out the processing time
   task automatic cmd(input logic [7:0] c);
      wr(OFF_CMD, {24'h000000, c});
      tick(8);
   endtask
   task automatic t_reset;
      st("status", 16'h03FF, 16'h009C);
      wr(OFF_STATUS, 32'h0000FFFF);
      st("status", 16'h03FF, 16'h009C);
      rdc("alarm_en", OFF_ALARM_EN, 32'h00000000);
      rdc("unmapped", 5'h18, 32'h00000000);
   endtask
   task automatic t_sec;
      init_done <= 1'b1;
      for (int s = 1; s < 4; s++) begin
         sec_state <= psa_sec_t'(s);
         tick(2);
         st("sec", 16'h0300, {6'h00, 2'(s), 8'h00});
         chk("rd_allow", s != 3, cfg_rd_allow);
         chk("wr_allow", 0, cfg_wr_allow);
      end
   endtask
   task automatic t_cmd;
      cmd(8'h01);
      chk("edit", 0, settings_edit_flag);
      rdc("rejected", OFF_CMD_STAT, 32'h00000002);
      sec_state <= PSA_SEC_PARTLY;
      wr(OFF_CMD, 32'h00000001);
      tick(3);
      chk("edit", 0, settings_edit_flag);
      tick(5);
      chk("edit", 1, settings_edit_flag);
      chk("wr_allow", 1, cfg_wr_allow);
      st("edit", 16'h0009, 16'h0009);
      cmd(8'h02);
      st("exit", 16'h0009, 16'h0000);
      sleep_criteria_ok <= 1'b1;
      cmd(8'h04);
      st("permit", 16'h0004, 16'h0000);
      chk("lowpow", 0, enter_low_power);
      cmd(8'h03);
      st("permit", 16'h0004, 16'h0004);
      chk("lowpow", 1, enter_low_power);
   endtask
   task automatic t_otp;
      otp_data_waiting <= 1'b1;
      tick(1);
      otp_data_waiting <= 1'b0;
      tick(2);
      st("otp", 16'h00C0, 16'h00C0);
      otp_cond_ok <= 1'b1;
      tick(2);
      st("otp", 16'h00C0, 16'h0040);
      otp_all_written <= 1'b1;
      tick(1);
      otp_all_written <= 1'b0;
      tick(2);
      st("otp", 16'h00C0, 16'h0080);
      sec_state <= PSA_SEC_OPEN;
      cmd(8'h01);
      st("otp_edit", 16'h00C0, 16'h0000);
      otp_cond_ok <= 1'b0;
      otp_data_waiting <= 1'b1;
      tick(1);
      otp_data_waiting <= 1'b0;
      tick(2);
      st("otp_edit", 16'h00C0, 16'h0000);
      cmd(8'h02);
   endtask
   task automatic t_io;
      ow_check_running <= 1'b1;
      tick(2);
      st("ow", 16'h0020, 16'h0000);
      ow_enable <= 1'b1;
      tick(2);
      st("ow", 16'h0020, 16'h0020);
      charge_request <= 1'b1;
      soft_charge_mode <= 1'b1;
      tick(2);
      st("soft", 16'h0002, 16'h0002);
      chk("sw", 2'b10, {soft_charge_switch, main_charge_switch});
      soft_charge_mode <= 1'b0;
      tick(2);
      chk("sw", 2'b01, {soft_charge_switch, main_charge_switch});
   endtask
   // second reset in mid-run: normal cause, full-reset flag comes back
   task automatic t_rst;
      {rst_n, wd_reset_cause} <= 2'b00;
      tick(2);
      rst_n <= 1'b1;
      tick(2);
      st("rst2", 16'h03FF, 16'h01AC);
   endtask
   task automatic t_alarm;
      alarm_raw_in <= 16'hFFFF;
      tick(3);
      rdc("alarm", OFF_ALARM, 32'h00000000);
      wr(OFF_ALARM_EN, 32'h0000FFFF);
      tick(3);
      rdc("alarm", OFF_ALARM, 32'h0000FEFD);
      chk("alert", 1, alert_out);
      scan_done <= 1'b1;
      tick(1);
      scan_done <= 1'b0;
      tick(2);
      rdc("alarm", OFF_ALARM, 32'h0000FEFF);
      alarm_raw_in <= 16'h8000;
      tick(2);
      wr(OFF_ALARM, 32'h0000FFFF);
      rdc("alarm", OFF_ALARM, 32'h00008000);
      wr(OFF_ALARM, 32'h00000000);
      rdc("alarm", OFF_ALARM, 32'h00008000);
      alarm_raw_in <= 16'h0000;
      tick(1);
      wr(OFF_ALARM, 32'h00008000);
      rdc("alarm", OFF_ALARM, 32'h00000000);
      chk("alert", 0, alert_out);
   endtask
   // main sequence
   initial begin
      {rst_n, init_done, otp_cond_ok, otp_data_waiting, otp_all_written, ow_enable} = 6'h00;
      {ow_check_running, sleep_criteria_ok, soft_charge_mode, charge_request, scan_done} = 5'h00;
      {wd_reset_cause, cfg_sleep_default} = 2'b11;
      alarm_raw_in = 16'h0000;
      sec_state = PSA_SEC_LOCKED;
      tick(12);
      rst_n <= 1'b1;
      tick(2);
      t_reset();
      t_sec();
      t_cmd();
      t_otp();
      t_io();
      t_rst();
      t_alarm();
      print_verdict();
   end
endmodule
